// ===== design/ets_regs.svh
// Register offsets, field positions, reset values and timing counts of the trigger sequencer.
// Assumes a 125 MHz system clock; offsets are word indices, byte address is four times the index.
`ifndef ETS_REGS_SVH
`define ETS_REGS_SVH

`define ETS_IDX_STATUS 7'h17
`define ETS_IDX_CTRL_TWO 7'h18
`define ETS_IDX_CLAMP_RISE 7'h66
`define ETS_IDX_CLAMP_FALL 7'h67
`define ETS_IDX_PIN5_RISE 7'h68
`define ETS_IDX_PIN5_FALL 7'h69
`define ETS_IDX_JACK_RISE 7'h6A
`define ETS_IDX_JACK_FALL 7'h6B
`define ETS_IDX_LVL_RISE 7'h6E
`define ETS_IDX_LVL_FALL 7'h6F
`define ETS_IDX_EDGE_CFG 7'h70

`define ETS_BIT_BUSY 9
`define ETS_BIT_BOOT_LAUNCH 1
`define ETS_BIT_LVL_ENABLE 6

`define ETS_STEP_RESET 9'h1FF
`define ETS_STEP_ABORT 9'h1FF
`define ETS_STEP_LAST 9'h1FD
`define ETS_STEP_BOOT 9'h180
`define ETS_CUR_RESET 9'h000
`define ETS_CFG_RESET 7'h00
`define ETS_WAIT_END 4'hF
`define ETS_WAIT_SHORT 4'h0

`define ETS_CLK_PS 8000
`define ETS_SHORT_PS 3300000
`define ETS_UNIT_PS 61440000
`define ETS_SHORT_CYC ((`ETS_SHORT_PS + `ETS_CLK_PS - 1) / `ETS_CLK_PS)
`define ETS_UNIT_CYC (`ETS_UNIT_PS / `ETS_CLK_PS)

`endif

// ===== design/ets_pkg.sv
// Types shared by the trigger sequencer.
// Assumes the constants of ets_regs.svh alongside.
package ets_pkg;
	typedef enum logic [1:0] {ETS_IDLE, ETS_FETCH, ETS_WAIT, ETS_DELAY} ets_state_t;
	typedef logic [8:0] ets_step_t;
endpackage : ets_pkg

// ===== design/ets_sequencer.sv
// Event-triggered write sequencer front end: edge triggers, request queue, step walker, AHB-Lite registers.
// Assumes a step memory outside that answers a fetch with its wait code one cycle later, and is not reset.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ets_regs.svh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// RL1 - Jack and pin-five signals launch sequences
// RL2 - Rising, falling or both edges configurable
// RL3 - Own 9-bit start step per edge
// RL4 - Start step 1FFh aborts sequence
// RL5 - Start steps reset to 1FFh
// RL6 - Step memory survives resets and sleep
// RL7 - Software keeps system clock running
// RL8 - Software makes boot enable system clock
// RL9 - Boot sequence runs before triggered ones
// RL10 - Level-detect edges launch when enabled
// RL11 - Second level unit never triggers
// RL12 - Level rise and fall step registers
// RL13 - One enable for both level edges
// RL14 - Boot runs after every reset, wake
// RL15 - Boot loads trim and user writes
// RL16 - Boot starts at step 384
// RL17 - Boot launch bit starts 180h
// RL18 - Software changes clock after boot only
// RL19 - Busy flag at bit 9
// RL20 - Current step field, resets 000h
// RL21 - Status feeds interrupt logic
// RL22 - Status selectable on general pin
// RL23 - Queue requests, run each in turn
// RL24 - Stop and flag when queue empty
// RL25 - Wait code 0xF ends sequence
// RL26 - Synchronise inputs, one request per edge
// RL27 - Busy spans all queued sequences
module ets_sequencer
	import ets_pkg::*;
#(
	parameter int unsigned UNIT_CYCLES = `ETS_UNIT_CYC // Cycles per long-wait unit
) (
	input wire logic clock, // System clock
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic jack_detect_signal, // Jack detect level
	input wire logic general_pin_five_signal, // Pin five level
	input wire logic mic_sense_clamp, // Mic clamp level
	input wire logic first_dynamic_range_unit, // Level-detect output of first unit
	input wire logic wake_boot_request, // Pulse on wake-up or soft reset
	output logic [8:0] step_read_index, // Step being fetched
	output logic step_read_strobe, // Fetch and execute strobe
	input wire logic [3:0] step_wait_code, // Wait code of fetched step
	output logic sequencer_busy_flag, // Busy status for pin mux
	output logic seq_done_pulse, // Queue drained, to interrupt logic
	input wire logic hsel, // AHB select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB ready in
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB ready out
	output logic hresp // AHB response
);

	localparam int unsigned NSRC = 9; // Eight edge sources and boot
	localparam int unsigned BOOT = 8;

	ets_state_t state_q;
	ets_step_t start_q [8];
	logic [6:0] cfg_q;
	logic [NSRC-1:0] pend_q;
	logic [NSRC-1:0] pend_set;
	logic [NSRC-1:0] pend_clr;
	ets_step_t cur_step_q;
	logic [3:0] code_q;
	logic [26:0] cnt_q;
	logic busy_q;
	logic done_q;
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic [3:0] s3_q;
	logic [7:0] edge_req;
	logic [7:0] edge_en;
	logic grant_any;
	logic [3:0] grant_src;
	ets_step_t grant_step;
	logic launch;
	logic seq_end;
	logic wr_pend_q;
	logic [6:0] wr_idx_q;
	logic boot_wr;
	logic [31:0] rd_d;

	//////////////////////////////////////////////////////////////////////////////
	// Trigger inputs: two-flop synchroniser, then edge detect on the settled copy
	assign edge_en = {{2{cfg_q[`ETS_BIT_LVL_ENABLE]}}, cfg_q[5:0]}; // RL13
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_trig
			logic raw;
			if (gi == 0) begin : g_c
				assign raw = mic_sense_clamp;
			end else if (gi == 1) begin : g_p
				assign raw = general_pin_five_signal; // RL1
			end else if (gi == 2) begin : g_j
				assign raw = jack_detect_signal; // RL1
			end else begin : g_l
				assign raw = first_dynamic_range_unit; // RL10 RL11
			end
			// Third stage only compares; the first stage feeds nothing else
			always_ff @(posedge clock or negedge arst_n) begin : p_sync
				if (!arst_n) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= raw; // RL26
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
				end
			end
			assign edge_req[2*gi] = s2_q[gi] & ~s3_q[gi] & edge_en[2*gi]; // RL2 RL26
			assign edge_req[2*gi+1] = ~s2_q[gi] & s3_q[gi] & edge_en[2*gi+1]; // RL2 RL26
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////////
	// Request queue: one pending bit per source, a new edge wins over the grant clear
	assign pend_set = {wake_boot_request | boot_wr, edge_req}; // RL14 RL17 RL23
	always_ff @(posedge clock or negedge arst_n) begin : p_pend
		if (!arst_n) begin
			pend_q <= 9'h100; // Boot queued from reset onward
		end else begin
			pend_q <= (pend_q & ~pend_clr) | pend_set; // RL23 RL26
		end
	end

	// Fixed priority, boot first so that wake-up setup precedes any trigger
	always_comb begin : p_grant
		grant_any = 1'b0;
		grant_src = 4'h0;
		grant_step = `ETS_STEP_BOOT;
		pend_clr = '0;
		if (pend_q[BOOT]) begin
			grant_any = 1'b1;
			grant_src = 4'(BOOT);
			grant_step = `ETS_STEP_BOOT; // RL9 RL15 RL16
		end else begin
			for (int i = 7; i >= 0; i--) begin
				if (pend_q[i]) begin
					grant_any = 1'b1;
					grant_src = 4'(i);
					grant_step = start_q[i]; // RL3 RL12
				end
			end
		end
		if (state_q == ETS_IDLE && grant_any) begin
			pend_clr[grant_src] = 1'b1;
		end
	end

	assign launch = state_q == ETS_IDLE && grant_any && grant_step != `ETS_STEP_ABORT; // RL4
	assign seq_end = state_q == ETS_DELAY && cnt_q == 27'h0000000 &&
		(code_q == `ETS_WAIT_END || cur_step_q == `ETS_STEP_LAST); // RL25

	//////////////////////////////////////////////////////////////////////////////
	// Step walker: fetch a step, take its wait code, wait, then go on or end
	always_ff @(posedge clock or negedge arst_n) begin : p_fsm
		if (!arst_n) begin
			state_q <= ETS_IDLE;
		end else begin
			unique case (state_q)
				ETS_IDLE: begin
					if (launch) begin
						state_q <= ETS_FETCH;
					end
				end
				ETS_FETCH: begin
					state_q <= ETS_WAIT;
				end
				ETS_WAIT: begin
					state_q <= ETS_DELAY;
				end
				ETS_DELAY: begin
					if (seq_end) begin
						state_q <= ETS_IDLE; // RL25
					end else if (cnt_q == 27'h0000000) begin
						state_q <= ETS_FETCH;
					end
				end
			endcase
		end
	end

	// Step index: loaded on launch, advanced after each completed wait that does not end the sequence
	always_ff @(posedge clock or negedge arst_n) begin : p_step
		if (!arst_n) begin
			cur_step_q <= `ETS_CUR_RESET; // RL20
			step_read_index <= `ETS_CUR_RESET;
		end else begin
			if (launch) begin
				step_read_index <= grant_step;
			end else if (state_q == ETS_DELAY && cnt_q == 27'h0000000 && !seq_end) begin
				step_read_index <= step_read_index + 9'h001;
			end
			if (state_q == ETS_FETCH) begin
				cur_step_q <= step_read_index; // RL20
			end
		end
	end

	// Wait counter; long waits are huge, so the unit is a parameter for short simulations
	always_ff @(posedge clock or negedge arst_n) begin : p_wait
		if (!arst_n) begin
			code_q <= 4'h0;
			cnt_q <= 27'h0000000;
		end else if (state_q == ETS_WAIT) begin
			code_q <= step_wait_code;
			if (step_wait_code == `ETS_WAIT_SHORT || step_wait_code == `ETS_WAIT_END) begin
				cnt_q <= 27'(`ETS_SHORT_CYC - 1);
			end else begin
				cnt_q <= 27'(UNIT_CYCLES * ((32'h1 << step_wait_code) - 32'h1) - 1);
			end
		end else if (state_q == ETS_DELAY && cnt_q != 27'h0000000) begin
			cnt_q <= cnt_q - 27'h0000001;
		end
	end

	// Step memory sits outside and is never reset here, so stored sequences outlive every reset
	assign step_read_strobe = state_q == ETS_FETCH; // RL6

	// Busy holds across back-to-back queued sequences; done pulses once the queue is drained
	always_ff @(posedge clock or negedge arst_n) begin : p_busy
		if (!arst_n) begin
			busy_q <= 1'b0; // RL19
			done_q <= 1'b0;
		end else begin
			if (state_q == ETS_IDLE) begin
				busy_q <= launch; // RL27
			end else if (seq_end) begin
				busy_q <= |pend_q; // RL27
			end
			done_q <= seq_end && pend_q == '0; // RL24
		end
	end

	assign sequencer_busy_flag = busy_q; // RL22
	assign seq_done_pulse = done_q; // RL21 RL24

	//////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait, always OKAY, word writes only, unmapped reads zero
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign boot_wr = wr_pend_q && wr_idx_q == `ETS_IDX_CTRL_TWO && hwdata[`ETS_BIT_BOOT_LAUNCH]; // RL17

	always_ff @(posedge clock or negedge arst_n) begin : p_addr
		if (!arst_n) begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= 7'h00;
		end else if (hready) begin
			wr_pend_q <= hsel && htrans[1] && hwrite && hsize == 3'b010;
			wr_idx_q <= haddr[8:2];
		end
	end

	// Start-step and edge configuration registers
	always_ff @(posedge clock or negedge arst_n) begin : p_regs
		if (!arst_n) begin
			for (int i = 0; i < 8; i++) begin
				start_q[i] <= `ETS_STEP_RESET; // RL5 RL12
			end
			cfg_q <= `ETS_CFG_RESET;
		end else if (wr_pend_q) begin
			if (wr_idx_q >= `ETS_IDX_CLAMP_RISE && wr_idx_q <= `ETS_IDX_JACK_FALL) begin
				start_q[3'(wr_idx_q - `ETS_IDX_CLAMP_RISE)] <= hwdata[8:0]; // RL3
			end else if (wr_idx_q == `ETS_IDX_LVL_RISE || wr_idx_q == `ETS_IDX_LVL_FALL) begin
				start_q[3'(wr_idx_q - `ETS_IDX_LVL_RISE + 7'h06)] <= hwdata[8:0]; // RL12
			end else if (wr_idx_q == `ETS_IDX_EDGE_CFG) begin
				cfg_q <= hwdata[6:0];
			end
		end
	end

	// Read mux in the address phase, registered into the data phase
	always_comb begin : p_rd
		rd_d = 32'h00000000;
		unique case (haddr[8:2])
			`ETS_IDX_STATUS: rd_d = {22'h000000, busy_q, cur_step_q}; // RL19 RL20
			`ETS_IDX_CLAMP_RISE: rd_d = {23'h000000, start_q[0]};
			`ETS_IDX_CLAMP_FALL: rd_d = {23'h000000, start_q[1]};
			`ETS_IDX_PIN5_RISE: rd_d = {23'h000000, start_q[2]};
			`ETS_IDX_PIN5_FALL: rd_d = {23'h000000, start_q[3]};
			`ETS_IDX_JACK_RISE: rd_d = {23'h000000, start_q[4]};
			`ETS_IDX_JACK_FALL: rd_d = {23'h000000, start_q[5]};
			`ETS_IDX_LVL_RISE: rd_d = {23'h000000, start_q[6]};
			`ETS_IDX_LVL_FALL: rd_d = {23'h000000, start_q[7]};
			`ETS_IDX_EDGE_CFG: rd_d = {25'h0000000, cfg_q};
			default: rd_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin : p_rdata
		if (!arst_n) begin
			hrdata <= 32'h00000000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata <= rd_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Checks
	a_boot_goes_first: assert property (@(posedge clock) disable iff (!arst_n) // RL9
		state_q == ETS_IDLE && pend_q[BOOT] |-> ##2 cur_step_q == `ETS_STEP_BOOT)
		else $error("boot request not served first at its start step");

	a_end_marker_stop: assert property (@(posedge clock) disable iff (!arst_n) // RL25
		state_q == ETS_DELAY && cnt_q == 27'h0000000 && code_q == `ETS_WAIT_END |=> state_q == ETS_IDLE)
		else $error("sequence ran past its end marker");

	a_busy_on_launch: assert property (@(posedge clock) disable iff (!arst_n) // RL27
		launch |=> busy_q ##1 step_read_strobe == 1'b0 && busy_q)
		else $error("busy not raised on launch");

	a_busy_fall_empty: assert property (@(posedge clock) disable iff (!arst_n) // RL27
		$fell(busy_q) |-> state_q == ETS_IDLE && !$past(launch))
		else $error("busy fell while work remained");

	a_done_when_idle: assert property (@(posedge clock) disable iff (!arst_n) // RL24
		seq_done_pulse |-> !busy_q && state_q == ETS_IDLE && $past(state_q) == ETS_DELAY)
		else $error("done pulse without a finished queue");

	a_edge_queues: assert property (@(posedge clock) disable iff (!arst_n) // RL26
		s2_q[2] && !s3_q[2] && cfg_q[4] |=> pend_q[4] || $past(launch) || state_q != ETS_IDLE)
		else $error("jack rising edge not queued");

	a_abort_skips: assert property (@(posedge clock) disable iff (!arst_n) // RL4
		state_q == ETS_IDLE && grant_any && grant_step == `ETS_STEP_ABORT |=> state_q == ETS_IDLE && !busy_q)
		else $error("aborted start step executed");

	a_level_gated: assert property (@(posedge clock) disable iff (!arst_n) // RL13
		!cfg_q[`ETS_BIT_LVL_ENABLE] && !pend_q[6] |=> !pend_q[6])
		else $error("level edge queued while disabled");

	a_boot_on_write: assert property (@(posedge clock) disable iff (!arst_n) // RL17
		boot_wr |=> pend_q[BOOT])
		else $error("boot launch write not queued");

	a_wake_queues: assert property (@(posedge clock) disable iff (!arst_n) // RL14
		wake_boot_request |=> pend_q[BOOT])
		else $error("wake-up did not queue the boot sequence");

	a_level_both_edges: assert property (@(posedge clock) disable iff (!arst_n) // RL10 RL13
		cfg_q[`ETS_BIT_LVL_ENABLE] && s2_q[3] != s3_q[3] |=> pend_q[6] || pend_q[7])
		else $error("enabled level-detect transition not queued");

	a_busy_while_walking: assert property (@(posedge clock) disable iff (!arst_n) // RL27
		state_q != ETS_IDLE |-> busy_q)
		else $error("busy low while a sequence runs");

	a_end_wait_short: assert property (@(posedge clock) disable iff (!arst_n) // RL25
		state_q == ETS_WAIT && step_wait_code == `ETS_WAIT_END |=>
		code_q == `ETS_WAIT_END && cnt_q == 27'(`ETS_SHORT_CYC - 1))
		else $error("end marker step did not take the short wait");

	a_step_follows: assert property (@(posedge clock) disable iff (!arst_n) // RL20
		step_read_strobe |=> cur_step_q == $past(step_read_index))
		else $error("current step not updated after a fetch");

	a_status_read: assert property (@(posedge clock) disable iff (!arst_n) // RL19 RL20
		hready && hsel && htrans[1] && !hwrite && haddr[8:2] == `ETS_IDX_STATUS |=>
		hrdata == {22'h000000, $past(busy_q), $past(cur_step_q)})
		else $error("status read does not show busy and current step");

endmodule : ets_sequencer

// ===== tb/ets_step_mem_model.sv
// Step memory beside the sequencer: answers each fetch with the wait code of that step.
// Assumes fetch strobe and index are sampled at the rising edge of the system clock.
`timescale 1ns/1ps
module ets_step_mem_model (
	input wire logic clock, // System clock
	input wire logic step_read_strobe, // Fetch strobe
	input wire logic [8:0] step_read_index, // Step fetched
	output logic [3:0] step_wait_code // Wait code answered
);
	logic [3:0] mem_q [0:511];

	//////////////////////////////////////////////////////////////////////////////
	// Every step ends its sequence except the first boot step; never reset, so contents outlive resets
	initial begin
		foreach (mem_q[i]) mem_q[i] = 4'hF;
		mem_q[9'h180] = 4'h0;
		step_wait_code = 4'h5;
	end

	// Answer stands one cycle; otherwise scrambled so a late sample shows up
	always @(posedge clock) begin
		if (step_read_strobe === 1'b1) begin
			step_wait_code <= mem_q[step_read_index];
		end else begin
			step_wait_code <= ~step_wait_code;
		end
	end
endmodule : ets_step_mem_model

// ===== tb/ets_sequencer_tb.sv
// Self-checking bench of the trigger sequencer: bus tasks, trigger stimulus, fetch and read monitor.
// Assumes the step memory model and a four-cycle long-wait unit to keep the run short.
`timescale 1ns/1ps
`include "ets_regs.svh"
module ets_sequencer_tb;
	logic clock = 1'b0, arst_n = 1'b0, jack_detect_signal = 1'b0, general_pin_five_signal = 1'b0;
	logic mic_sense_clamp = 1'b0, first_dynamic_range_unit = 1'b0, wake_boot_request = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, rd_dp = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rnd_q = 32'hBE37;
	logic [8:0] step_read_index, stp;
	logic [3:0] step_wait_code;
	logic step_read_strobe, sequencer_busy_flag, seq_done_pulse, hreadyout, hresp;
	logic [8:0] exp_step [$];
	logic [31:0] exp_rd [$];
	int bad_count = 0, checked = 0, cyc_q = 0, done_cnt = 0, d0;
	localparam logic [6:0] STEP_REGS [8] = '{`ETS_IDX_CLAMP_RISE, `ETS_IDX_CLAMP_FALL, `ETS_IDX_PIN5_RISE,
		`ETS_IDX_PIN5_FALL, `ETS_IDX_JACK_RISE, `ETS_IDX_JACK_FALL, `ETS_IDX_LVL_RISE, `ETS_IDX_LVL_FALL};

	ets_sequencer #(.UNIT_CYCLES(4)) dut (.clock(clock), .arst_n(arst_n), .jack_detect_signal(jack_detect_signal),
		.general_pin_five_signal(general_pin_five_signal), .mic_sense_clamp(mic_sense_clamp),
		.first_dynamic_range_unit(first_dynamic_range_unit), .wake_boot_request(wake_boot_request),
		.step_read_index(step_read_index), .step_read_strobe(step_read_strobe), .step_wait_code(step_wait_code),
		.sequencer_busy_flag(sequencer_busy_flag), .seq_done_pulse(seq_done_pulse), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp));
	ets_step_mem_model mem (.clock(clock), .step_read_strobe(step_read_strobe),
		.step_read_index(step_read_index), .step_wait_code(step_wait_code));

	//////////////////////////////////////////////////////////////////////////////
	// 125 MHz clock
	always #4 clock = ~clock;

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_sim

	// Single word transfer; for a read, data is the expected value and goes to the monitor's queue
	task automatic ahb(input logic wr, input logic [6:0] idx, input logic [31:0] data);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {23'h0, idx, 2'b00};
		hwrite <= wr;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= data;
		rd_dp <= !wr;
		if (!wr) exp_rd.push_back(data);
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		rd_dp <= 1'b0;
	endtask : ahb

	// Boot always walks two steps in the model memory
	task automatic expect_seq(input logic [8:0] start);
		exp_step.push_back(start);
		if (start == `ETS_STEP_BOOT) exp_step.push_back(start + 9'h1);
	endtask : expect_seq

	// Trigger latency first, then wait for every noted fetch and for idle
	task automatic settle();
		repeat (10) @(posedge clock);
		while (sequencer_busy_flag !== 1'b0 || exp_step.size() != 0) @(posedge clock);
	endtask : settle

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] r;
		r = v ^ (v << 13);
		r = r ^ (r >> 17);
		return r ^ (r << 5);
	endfunction : xs

	//////////////////////////////////////////////////////////////////////////////
	// Monitor: every fetch and every read data phase takes the oldest note; also the hang limit
	always @(posedge clock) begin
		cyc_q <= cyc_q + 1;
		if (seq_done_pulse === 1'b1) done_cnt <= done_cnt + 1;
		if (step_read_strobe === 1'b1) begin
			if (exp_step.size() == 0) check("unexpected fetch", {23'h0, step_read_index}, 32'hFFFFFFFF);
			else check("fetch step", {23'h0, step_read_index}, {23'h0, exp_step.pop_front()});
		end
		if (rd_dp && hreadyout === 1'b1) check("read data", hrdata, exp_rd.pop_front());
		if (rd_dp) check("bus response", {31'h0, hresp}, 32'h0);
		if (cyc_q == 30000) begin
			bad_count++;
			end_sim();
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		expect_seq(`ETS_STEP_BOOT);
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		repeat (5) @(posedge clock);
		ahb(1'b0, `ETS_IDX_STATUS, 32'h380);
		settle();
		ahb(1'b1, `ETS_IDX_STATUS, 32'hFFFF);
		ahb(1'b0, `ETS_IDX_STATUS, 32'h181);
		for (int i = 0; i < 8; i++) ahb(1'b0, STEP_REGS[i], 32'h1FF);
		ahb(1'b0, 7'h7F, 32'h0);
		ahb(1'b0, `ETS_IDX_CTRL_TWO, 32'h0);
		// Random start steps on jack rise; the fall edge keeps 1FFh and must abort
		for (int i = 0; i < 3; i++) begin
			rnd_q = xs(rnd_q);
			stp = rnd_q[8:0] % 9'h1FE;
			ahb(1'b1, `ETS_IDX_JACK_RISE, {23'h0, stp});
			ahb(1'b0, `ETS_IDX_JACK_RISE, {23'h0, stp});
			ahb(1'b1, `ETS_IDX_EDGE_CFG, 32'h30);
			expect_seq(stp);
			@(posedge clock) jack_detect_signal <= 1'b1;
			settle();
			@(posedge clock) jack_detect_signal <= 1'b0;
			repeat (12) @(posedge clock);
			check("busy after abort", {31'h0, sequencer_busy_flag}, 32'h0);
		end
		// Pin five fall only, level detect both edges; simultaneous falls queue behind one busy span
		ahb(1'b1, `ETS_IDX_PIN5_FALL, 32'h55);
		ahb(1'b1, `ETS_IDX_LVL_RISE, 32'h20);
		ahb(1'b1, `ETS_IDX_LVL_FALL, 32'h30);
		ahb(1'b1, `ETS_IDX_EDGE_CFG, 32'h48);
		expect_seq(9'h020);
		@(posedge clock) begin
			general_pin_five_signal <= 1'b1;
			first_dynamic_range_unit <= 1'b1;
		end
		settle();
		repeat (2) @(posedge clock); // Let the monitor count the pulse of the level rise first
		d0 = done_cnt;
		expect_seq(9'h055);
		expect_seq(9'h030);
		@(posedge clock) begin
			general_pin_five_signal <= 1'b0;
			first_dynamic_range_unit <= 1'b0;
		end
		settle();
		repeat (3) @(posedge clock);
		check("done pulses", done_cnt - d0, 32'h1);
		ahb(1'b1, `ETS_IDX_EDGE_CFG, 32'h00);
		@(posedge clock) first_dynamic_range_unit <= 1'b1;
		repeat (12) @(posedge clock);
		// Boot by launch bit, then wake together with a clamp rise
		expect_seq(`ETS_STEP_BOOT);
		ahb(1'b1, `ETS_IDX_CTRL_TWO, 32'h2);
		settle();
		ahb(1'b1, `ETS_IDX_CLAMP_RISE, 32'h0FE);
		ahb(1'b1, `ETS_IDX_EDGE_CFG, 32'h01);
		expect_seq(`ETS_STEP_BOOT);
		expect_seq(9'h0FE);
		// Clamp edge and wake reach the queue in one cycle, so boot must win on priority
		@(posedge clock) mic_sense_clamp <= 1'b1;
		repeat (2) @(posedge clock);
		wake_boot_request <= 1'b1;
		@(posedge clock) wake_boot_request <= 1'b0;
		settle();
		// Hardware reset while idle: boot runs again from kept memory, start steps return to 1FFh
		expect_seq(`ETS_STEP_BOOT);
		@(posedge clock) arst_n <= 1'b0;
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		ahb(1'b0, `ETS_IDX_CLAMP_RISE, 32'h1FF);
		settle();
		end_sim();
	end
endmodule : ets_sequencer_tb
